// ---- hw/dual_alarm_comparator.sv ----
// Dual alarm comparator: AHB-Lite register slave, seconds timebase,
// display alternation, menu ordering, interrupt, two alarm channels.
// Assumes the display value and AHB signals share REF_CLK_IN; the
// accept button and option strap are pins and are synchronised here.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`include "alarm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dual_alarm_comparator
	import alarm_pkg::*;
#(
	parameter int SEC_CYCLES = `CLK_FREQ_HZ * `TICK_PERIOD_S
)
(
	input  wire logic               REF_CLK_IN,
	input  wire logic               RST_IN,
	input  wire logic               HSEL_IN,
	input  wire logic        [31:0] HADDR_IN,
	input  wire logic        [1:0]  HTRANS_IN,
	input  wire logic               HWRITE_IN,
	input  wire logic        [2:0]  HSIZE_IN,
	input  wire logic        [31:0] HWDATA_IN,
	input  wire logic               HREADY_IN,
	output var  logic        [31:0] HRDATA_OUT,
	output var  logic               HREADYOUT_OUT,
	output var  logic               HRESP_OUT,
	input  wire logic signed [15:0] DISPLAY_VALUE_IN,
	input  wire logic               ACCEPT_BUTTON_IN,
	input  wire logic               ALARM_FITTED_IN,
	input  wire logic               MENU_NEXT_IN,
	output var  logic        [3:0]  MENU_ITEM_OUT,
	output var  logic        [1:0]  DISPLAY_SHOW_OUT,
	output var  logic               SWITCH1_CLOSED_OUT,
	output var  logic               SWITCH2_CLOSED_OUT,
	output var  logic               IRQ_OUT
);
	localparam logic [25:0] SEC_LAST = 26'(SEC_CYCLES - 1);

	// Clamp a written setpoint into the displayable and loop-valid span
	function automatic logic signed [15:0] clamp_level(input logic signed [15:0] v,
		input logic signed [15:0] lo, input logic signed [15:0] hi);
		logic signed [15:0] l;
		logic signed [15:0] h;
		l = (lo < `DISP_MIN) ? `DISP_MIN : lo;
		h = (hi > `DISP_MAX) ? `DISP_MAX : hi;
		clamp_level = (v < l) ? l : ((v > h) ? h : v);
	endfunction

	// Clamp a time in seconds to the largest programmable figure
	function automatic logic [11:0] clamp_time(input logic [31:0] v);
		clamp_time = (v > 32'(`TIME_MAX)) ? `TIME_MAX : v[11:0];
	endfunction

	alarm_ch_if ch_if[2] ();

	logic        [7:0]  ctrl_r, ctrl_nxt;
	logic signed [15:0] level_r[2], level_nxt[2];
	logic        [15:0] db_r[2], db_nxt[2];
	logic        [11:0] dly_r[2], dly_nxt[2];
	logic        [11:0] sil_r[2], sil_nxt[2];
	logic signed [15:0] lim_lo_r, lim_lo_nxt, lim_hi_r, lim_hi_nxt;
	logic        [3:0]  status_r, status_nxt, mask_r, mask_nxt;
	logic        [31:0] rdata_r, rdata_nxt;
	logic               wr_pend_r, wr_pend_nxt;
	logic        [7:0]  wr_ofs_r, wr_ofs_nxt;
	logic               irq_r, irq_nxt;
	logic        [1:0]  trip_prev_r;
	logic        [1:0]  trip_w, cond_w, silenced_w, sw_w;
	logic        [3:0]  events_w;
	logic               addr_ok_w;
	logic        [7:0]  addr_ofs_w;
	logic        [25:0] sec_cnt_r, sec_cnt_nxt;
	logic               tick_r, tick_nxt;
	logic        [2:0]  btn_sync_r;
	logic        [1:0]  fit_sync_r;
	logic               fitted_r, fitted_nxt, fit_held_r;
	logic        [1:0]  fit_arm_r;
	menu_t              menu_r, menu_nxt;
	show_t              show_r, show_nxt;
	logic               next_tag_r, next_tag_nxt;

	// ==========================================================
	// Alarm channels
	for (genvar g = 0; g < 2; g++)
	begin : g_ch
		assign ch_if[g].enable           = ctrl_r[g*`CTRL_STRIDE + `CTRL_EN_BIT];
		assign ch_if[g].sense_high       = ctrl_r[g*`CTRL_STRIDE + `CTRL_HIGH_BIT];
		assign ch_if[g].close_on_alarm   = ctrl_r[g*`CTRL_STRIDE + `CTRL_CLOSE_BIT];
		assign ch_if[g].first_trip_level = level_r[g];
		assign ch_if[g].trip_deadband    = db_r[g];
		assign ch_if[g].trip_delay_time  = dly_r[g];
		assign ch_if[g].silence_duration = sil_r[g];
		assign ch_if[g].accept           = btn_sync_r[1] && !btn_sync_r[2];
		assign trip_w[g]     = ch_if[g].tripped;
		assign cond_w[g]     = ch_if[g].cond;
		assign silenced_w[g] = ch_if[g].silenced;
		assign sw_w[g]       = ch_if[g].switch_closed;
		// Identical channels, each with its own settings
		alarm_channel u_ch (
			.clk_in     (REF_CLK_IN),
			.rst_in     (RST_IN),
			.tick_in    (tick_r),
			.display_in (DISPLAY_VALUE_IN),
			.ch         (ch_if[g])
		);
	end

	// ==========================================================
	// Register bus: zero wait state, read data sampled from the address phase
	always_comb
	begin
		addr_ok_w   = HSEL_IN && HREADY_IN && HTRANS_IN[1];
		addr_ofs_w  = {HADDR_IN[7:2], 2'b00};
		ctrl_nxt    = ctrl_r;
		level_nxt   = level_r;
		db_nxt      = db_r;
		dly_nxt     = dly_r;
		sil_nxt     = sil_r;
		lim_lo_nxt  = lim_lo_r;
		lim_hi_nxt  = lim_hi_r;
		mask_nxt    = mask_r;
		wr_pend_nxt = addr_ok_w && HWRITE_IN;
		wr_ofs_nxt  = addr_ok_w ? addr_ofs_w : wr_ofs_r;
		rdata_nxt   = rdata_r;
		// Data phase of a write lands in the register captured at its address phase
		if (wr_pend_r)
		begin
			case (wr_ofs_r)
				`OFS_CTRL:   ctrl_nxt = HWDATA_IN[7:0];
				`OFS_SP0:    level_nxt[0] = clamp_level(HWDATA_IN[15:0], lim_lo_r, lim_hi_r);
				`OFS_SP1:    level_nxt[1] = clamp_level(HWDATA_IN[15:0], lim_lo_r, lim_hi_r);
				`OFS_DB0:    db_nxt[0] = HWDATA_IN[15:0];
				`OFS_DB1:    db_nxt[1] = HWDATA_IN[15:0];
				`OFS_DLY0:   dly_nxt[0] = clamp_time(HWDATA_IN);
				`OFS_DLY1:   dly_nxt[1] = clamp_time(HWDATA_IN);
				`OFS_SIL0:   sil_nxt[0] = clamp_time(HWDATA_IN);
				`OFS_SIL1:   sil_nxt[1] = clamp_time(HWDATA_IN);
				`OFS_LIM_LO: lim_lo_nxt = HWDATA_IN[15:0];
				`OFS_LIM_HI: lim_hi_nxt = HWDATA_IN[15:0];
				`OFS_MASK:   mask_nxt = HWDATA_IN[3:0];
				default:     mask_nxt = mask_r;
			endcase
		end
		// Unmapped reads return zero
		if (addr_ok_w && !HWRITE_IN)
		begin
			case (addr_ofs_w)
				`OFS_CTRL:   rdata_nxt = {24'h000000, ctrl_r};
				`OFS_SP0:    rdata_nxt = {16'h0000, level_r[0]};
				`OFS_SP1:    rdata_nxt = {16'h0000, level_r[1]};
				`OFS_DB0:    rdata_nxt = {16'h0000, db_r[0]};
				`OFS_DB1:    rdata_nxt = {16'h0000, db_r[1]};
				`OFS_DLY0:   rdata_nxt = {20'h00000, dly_r[0]};
				`OFS_DLY1:   rdata_nxt = {20'h00000, dly_r[1]};
				`OFS_SIL0:   rdata_nxt = {20'h00000, sil_r[0]};
				`OFS_SIL1:   rdata_nxt = {20'h00000, sil_r[1]};
				`OFS_LIM_LO: rdata_nxt = {16'h0000, lim_lo_r};
				`OFS_LIM_HI: rdata_nxt = {16'h0000, lim_hi_r};
				`OFS_STATUS: rdata_nxt = {28'h0000000, status_r};
				`OFS_MASK:   rdata_nxt = {28'h0000000, mask_r};
				`OFS_STATE:  rdata_nxt = {20'h00000, show_r, fitted_r, 1'b0,
					sw_w, silenced_w, trip_w, cond_w};
				default:     rdata_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (RST_IN)
		begin
			ctrl_r        <= `CTRL_RESET;
			level_r       <= '{`SP_RESET, `SP_RESET};
			db_r          <= '{`DB_RESET, `DB_RESET};
			dly_r         <= '{`TIME_RESET, `TIME_RESET};
			sil_r         <= '{`TIME_RESET, `TIME_RESET};
			lim_lo_r      <= `DISP_MIN;
			lim_hi_r      <= `DISP_MAX;
			mask_r        <= 4'h0;
			wr_pend_r     <= 1'b0;
			wr_ofs_r      <= 8'h00;
			rdata_r       <= 32'h00000000;
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT     <= 1'b0;
		end
		else
		begin
			ctrl_r        <= ctrl_nxt;
			level_r       <= level_nxt;
			db_r          <= db_nxt;
			dly_r         <= dly_nxt;
			sil_r         <= sil_nxt;
			lim_lo_r      <= lim_lo_nxt;
			lim_hi_r      <= lim_hi_nxt;
			mask_r        <= mask_nxt;
			wr_pend_r     <= wr_pend_nxt;
			wr_ofs_r      <= wr_ofs_nxt;
			rdata_r       <= rdata_nxt;
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT     <= 1'b0;
		end
	end
	assign HRDATA_OUT = rdata_r;

	// ==========================================================
	// Interrupt: trip and clear edges are sticky; a status read clears,
	// but an edge in that same cycle still lands
	always_comb
	begin
		events_w   = {trip_prev_r & ~trip_w, trip_w & ~trip_prev_r};
		status_nxt = ((addr_ok_w && !HWRITE_IN && addr_ofs_w == `OFS_STATUS)
			? 4'h0 : status_r) | events_w;
		irq_nxt    = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (RST_IN)
		begin
			status_r    <= 4'h0;
			trip_prev_r <= 2'b00;
			irq_r       <= 1'b0;
		end
		else
		begin
			status_r    <= status_nxt;
			trip_prev_r <= trip_w;
			irq_r       <= irq_nxt;
		end
	end
	assign IRQ_OUT = irq_r;

	// ==========================================================
	// Seconds timebase and display alternation between value and tag
	always_comb
	begin
		tick_nxt     = (sec_cnt_r == SEC_LAST);
		sec_cnt_nxt  = tick_nxt ? 26'h0000000 : sec_cnt_r + 26'h0000001;
		show_nxt     = show_r;
		next_tag_nxt = next_tag_r;
		if (trip_w == 2'b00)
			show_nxt = SHOW_VALUE;
		else if (tick_r)
		begin
			// With both active the tags take turns between value phases
			case (show_r)
				SHOW_VALUE:
				begin
					show_nxt = (trip_w[1] && (next_tag_r || !trip_w[0])) ? SHOW_TAG2 : SHOW_TAG1;
					next_tag_nxt = !next_tag_r;
				end
				default: show_nxt = SHOW_VALUE;
			endcase
		end
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (RST_IN)
		begin
			sec_cnt_r  <= 26'h0000000;
			tick_r     <= 1'b0;
			show_r     <= SHOW_VALUE;
			next_tag_r <= 1'b0;
		end
		else
		begin
			sec_cnt_r  <= sec_cnt_nxt;
			tick_r     <= tick_nxt;
			show_r     <= show_nxt;
			next_tag_r <= next_tag_nxt;
		end
	end
	assign DISPLAY_SHOW_OUT = show_r;

	// ==========================================================
	// Pin synchronisers; the strap is caught at the third edge after reset,
	// once both synchroniser stages hold the pin rather than their reset value
	always_comb
	begin
		fitted_nxt = fit_held_r ? fitted_r : fit_sync_r[1];
		menu_nxt   = menu_r;
		if (MENU_NEXT_IN)
		begin
			case (menu_r)
				M_COND:  menu_nxt = fitted_r ? M_ENABLE : M_PBUTTON;
				M_ACCESS: menu_nxt = M_PBUTTON;
				M_CODE:  menu_nxt = M_ROOT;
				default: menu_nxt = menu_t'(menu_r + 4'h1);
			endcase
		end
	end

	always_ff @(posedge REF_CLK_IN)
	begin
		if (RST_IN)
		begin
			btn_sync_r <= 3'b000;
			fit_sync_r <= 2'b00;
			fit_arm_r  <= 2'b00;
			fit_held_r <= 1'b0;
			fitted_r   <= 1'b0;
			menu_r     <= M_ROOT;
		end
		else
		begin
			btn_sync_r <= {btn_sync_r[1:0], ACCEPT_BUTTON_IN};
			fit_sync_r <= {fit_sync_r[0], ALARM_FITTED_IN};
			fit_arm_r  <= {fit_arm_r[0], 1'b1};
			fit_held_r <= fit_arm_r[1];
			fitted_r   <= fitted_nxt;
			menu_r     <= menu_nxt;
		end
	end
	assign MENU_ITEM_OUT      = menu_r;
	assign SWITCH1_CLOSED_OUT = sw_w[0];
	assign SWITCH2_CLOSED_OUT = sw_w[1];
endmodule
`default_nettype wire

// ---- hw/alarm_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the alarm comparator.
// Included by the comparator top module only; defines only.
`ifndef ALARM_CFG_SVH
`define ALARM_CFG_SVH

// ==========================================================
// Register byte offsets
`define OFS_CTRL      8'h00
`define OFS_SP0       8'h04
`define OFS_SP1       8'h08
`define OFS_DB0       8'h0C
`define OFS_DB1       8'h10
`define OFS_DLY0      8'h14
`define OFS_DLY1      8'h18
`define OFS_SIL0      8'h1C
`define OFS_SIL1      8'h20
`define OFS_LIM_LO    8'h24
`define OFS_LIM_HI    8'h28
`define OFS_STATUS    8'h2C
`define OFS_MASK      8'h30
`define OFS_STATE     8'h34

// ==========================================================
// Control fields, three bits per channel starting at channel*4
`define CTRL_EN_BIT    0
`define CTRL_HIGH_BIT  1
`define CTRL_CLOSE_BIT 2
`define CTRL_STRIDE    4
`define CTRL_RESET     8'h00

// ==========================================================
// Value limits and reset values
`define DISP_MAX       16'sh4E1F
`define DISP_MIN       -16'sh4E1F
`define TIME_MAX       12'hE10
`define SP_RESET       16'h0000
`define DB_RESET       16'h0000
`define TIME_RESET     12'h000

// ==========================================================
// Timebase: one-second enable derived from the 40 MHz clock
`define CLK_FREQ_HZ    40000000
`define TICK_PERIOD_S  1

`endif

// ---- hw/alarm_pkg.sv ----
// Types shared by the alarm comparator modules.
// Assumes alarm_cfg.svh is on the include path.
package alarm_pkg;
	// Main programming menu items, in menu order
	typedef enum logic [3:0] {
		M_ROOT, M_RES, M_DP, M_CAL, M_SET, M_COND,
		M_ENABLE, M_TRIP_LEVEL, M_SENSE, M_POLARITY, M_DEADBAND,
		M_DELAY, M_SILENCE, M_ACCESS, M_PBUTTON, M_CODE
	} menu_t;

	// What the display shows in the current phase
	typedef enum logic [1:0] {
		SHOW_VALUE, SHOW_TAG1, SHOW_TAG2
	} show_t;
endpackage

// ---- hw/alarm_ch_if.sv ----
// Carrier between the comparator top and one alarm channel.
// Configuration flows to the channel, state flows back.
`timescale 1ns/1ps
`default_nettype none
interface alarm_ch_if;
	logic               enable;
	logic               sense_high;
	logic               close_on_alarm;
	logic signed [15:0] first_trip_level;
	logic        [15:0] trip_deadband;
	logic        [11:0] trip_delay_time;
	logic        [11:0] silence_duration;
	logic               accept;
	logic               cond;
	logic               tripped;
	logic               silenced;
	logic               switch_closed;

	modport ctrl (output enable, sense_high, close_on_alarm, first_trip_level,
		trip_deadband, trip_delay_time, silence_duration, accept,
		input cond, tripped, silenced, switch_closed);
	modport chan (input enable, sense_high, close_on_alarm, first_trip_level,
		trip_deadband, trip_delay_time, silence_duration, accept,
		output cond, tripped, silenced, switch_closed);
endinterface
`default_nettype wire

// ---- hw/alarm_channel.sv ----
// One alarm channel: compare, hysteresis, activation delay, silence, switch state.
// Assumes a one-cycle seconds tick and a display value on the same clock.
`timescale 1ns/1ps
`default_nettype none
module alarm_channel
	import alarm_pkg::*;
(
	input  wire logic               clk_in,
	input  wire logic               rst_in,
	input  wire logic               tick_in,
	input  wire logic signed [15:0] display_in,
	alarm_ch_if.chan                ch
);
	logic               cond_r, cond_nxt;
	logic               trip_r, trip_nxt;
	logic               sil_r, sil_nxt;
	logic               sw_r, sw_nxt;
	logic        [11:0] dly_cnt_r, dly_cnt_nxt;
	logic        [11:0] sil_cnt_r, sil_cnt_nxt;
	logic signed [17:0] disp_w, level_w, clr_hi_w, clr_lo_w;

	// ==========================================================
	// Next state
	always_comb
	begin
		disp_w   = 18'(display_in);
		level_w  = 18'(ch.first_trip_level);
		clr_hi_w = level_w - signed'({2'b00, ch.trip_deadband});
		clr_lo_w = level_w + signed'({2'b00, ch.trip_deadband});
		// Condition with hysteresis; disabled channel keeps settings but never trips
		if (!ch.enable)
			cond_nxt = 1'b0;
		else if (ch.sense_high)
			cond_nxt = cond_r ? !(disp_w < clr_hi_w) : (disp_w >= level_w);
		else
			cond_nxt = cond_r ? !(disp_w > clr_lo_w) : (disp_w <= level_w);
		// Seconds counted while the condition holds; zero delay trips at once
		dly_cnt_nxt = dly_cnt_r;
		if (!cond_r)
			dly_cnt_nxt = 12'h000;
		else if (tick_in && !trip_r && dly_cnt_r < ch.trip_delay_time)
			dly_cnt_nxt = dly_cnt_r + 12'h001;
		trip_nxt = cond_r && (trip_r || dly_cnt_r >= ch.trip_delay_time);
		// Accept silences the output only, the tripped state stays for the display
		sil_nxt = sil_r;
		sil_cnt_nxt = sil_cnt_r;
		if (!trip_r)
		begin
			sil_nxt = 1'b0;
			sil_cnt_nxt = 12'h000;
		end
		else if (ch.accept && ch.silence_duration != 12'h000 && !sil_r)
		begin
			sil_nxt = 1'b1;
			sil_cnt_nxt = ch.silence_duration;
		end
		else if (sil_r && tick_in)
		begin
			sil_nxt = sil_cnt_r > 12'h001;
			sil_cnt_nxt = sil_cnt_r - 12'h001;
		end
		// Polarity picks the switch state in alarm, the other one otherwise
		sw_nxt = (trip_r && !sil_r) ? ch.close_on_alarm : !ch.close_on_alarm;
	end

	// ==========================================================
	// State registers; the switch resets open, like an unpowered output
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			cond_r    <= 1'b0;
			trip_r    <= 1'b0;
			sil_r     <= 1'b0;
			sw_r      <= 1'b0;
			dly_cnt_r <= 12'h000;
			sil_cnt_r <= 12'h000;
		end
		else
		begin
			cond_r    <= cond_nxt;
			trip_r    <= trip_nxt;
			sil_r     <= sil_nxt;
			sw_r      <= sw_nxt;
			dly_cnt_r <= dly_cnt_nxt;
			sil_cnt_r <= sil_cnt_nxt;
		end
	end

	assign ch.cond          = cond_r;
	assign ch.tripped       = trip_r;
	assign ch.silenced      = sil_r;
	assign ch.switch_closed = sw_r;
endmodule
`default_nettype wire

// ---- dv/dual_alarm_comparator_asserts.sv ----
// Concurrent checks on the alarm comparator's top-level ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module dual_alarm_comparator_asserts
#(
	parameter int SEC_CYCLES = 40000000
)
(
	input  wire logic        REF_CLK_IN,
	input  wire logic        RST_IN,
	input  wire logic        HSEL_IN,
	input  wire logic [31:0] HADDR_IN,
	input  wire logic [1:0]  HTRANS_IN,
	input  wire logic        HWRITE_IN,
	input  wire logic        HREADY_IN,
	input  wire logic [31:0] HRDATA_OUT,
	input  wire logic        HREADYOUT_OUT,
	input  wire logic        HRESP_OUT,
	input  wire logic        ALARM_FITTED_IN,
	input  wire logic        MENU_NEXT_IN,
	input  wire logic [3:0]  MENU_ITEM_OUT,
	input  wire logic [1:0]  DISPLAY_SHOW_OUT,
	input  wire logic        IRQ_OUT
);
	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (RST_IN);

	// ==========================================================
	// Bus transfers
	// Read accepted in an address phase; read data must not drift otherwise
	logic rd_req;
	assign rd_req = HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN;
	ready_always_a: assert property (HREADYOUT_OUT)
		else $error("slave inserted a wait state");
	resp_okay_a: assert property (!HRESP_OUT)
		else $error("slave answered with an error response");
	rdata_hold_a: assert property (!rd_req |=> $stable(HRDATA_OUT))
		else $error("read data moved without a read");
	unmapped_zero_a: assert property (rd_req && HADDR_IN inside {[32'h38:32'hFC]}
		|=> HRDATA_OUT == 32'h0)
		else $error("unmapped read returned nonzero data");
	// Reset must win even while the default disable is active
	reset_clear_a: assert property (disable iff (1'b0) RST_IN |=> HRDATA_OUT == 32'h0
		&& !IRQ_OUT && DISPLAY_SHOW_OUT == 2'h0 && MENU_ITEM_OUT == 4'h0)
		else $error("outputs not cleared by reset");

	// ==========================================================
	// Menu order and display phases
	sequence at_cond;
		MENU_NEXT_IN && MENU_ITEM_OUT == 4'h5;
	endsequence
	sequence at_tail;
		MENU_NEXT_IN && MENU_ITEM_OUT inside {4'hD, 4'hF};
	endsequence
	menu_hold_a: assert property (!MENU_NEXT_IN |=> $stable(MENU_ITEM_OUT))
		else $error("menu moved without a step");
	menu_step_a: assert property (MENU_NEXT_IN
		&& !(MENU_ITEM_OUT inside {4'h5, 4'hD, 4'hF})
		|=> MENU_ITEM_OUT == $past(MENU_ITEM_OUT) + 4'h1)
		else $error("menu did not step to the next item");
	menu_option_a: assert property (at_cond |=> MENU_ITEM_OUT ==
		($past(ALARM_FITTED_IN) ? 4'h6 : 4'hE))
		else $error("alarm items misplaced after conditioning");
	menu_tail_a: assert property (at_tail |=> MENU_ITEM_OUT ==
		($past(MENU_ITEM_OUT) == 4'hD ? 4'hE : 4'h0))
		else $error("menu tail order wrong");
	show_code_a: assert property (DISPLAY_SHOW_OUT != 2'h3)
		else $error("display phase code out of range");
endmodule

bind dual_alarm_comparator dual_alarm_comparator_asserts #(.SEC_CYCLES(SEC_CYCLES)) chk_u (
	.REF_CLK_IN(REF_CLK_IN),
	.RST_IN(RST_IN),
	.HSEL_IN(HSEL_IN),
	.HADDR_IN(HADDR_IN),
	.HTRANS_IN(HTRANS_IN),
	.HWRITE_IN(HWRITE_IN),
	.HREADY_IN(HREADY_IN),
	.HRDATA_OUT(HRDATA_OUT),
	.HREADYOUT_OUT(HREADYOUT_OUT),
	.HRESP_OUT(HRESP_OUT),
	.ALARM_FITTED_IN(ALARM_FITTED_IN),
	.MENU_NEXT_IN(MENU_NEXT_IN),
	.MENU_ITEM_OUT(MENU_ITEM_OUT),
	.DISPLAY_SHOW_OUT(DISPLAY_SHOW_OUT),
	.IRQ_OUT(IRQ_OUT)
);
`default_nettype wire

// ---- dv/annunciator_model.sv ----
// Sounder on one switched alarm circuit.
// Assumes a plain load with no latching of its own.
`timescale 1ns/1ps
`default_nettype none
module annunciator_model
(
	input  wire logic closed_in,
	output logic      sounding_out
);
	// A closed switch completes the circuit; no memory, so it follows at once
	assign sounding_out = closed_in;
endmodule
`default_nettype wire

// ---- dv/dual_alarm_comparator_tb.sv ----
// Self-checking bench for the dual alarm comparator.
// Assumes package, design, checker and sounder model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dual_alarm_comparator_tb;
	localparam int SEC = 20; // Short seconds tick keeps delays cheap
	logic               clk, rst, hsel, hwrite, accept, fitted, mnext;
	logic        [31:0] haddr, hwdata, hrdata, rd;
	logic        [1:0]  htrans, show;
	logic        [2:0]  hsize;
	logic        [3:0]  item, exp_item;
	logic signed [15:0] disp;
	logic               hrdy, hresp, sw1, sw2, irq, snd1, snd2;
	int                 errors, checks, cycles, seed, lvl, k;
	int                 tv [7] = '{99, 100, 80, 79, -50, -40, -39};
	logic        [1:0]  te [7] = '{2'h2, 2'h0, 2'h0, 2'h2, 2'h3, 2'h3, 2'h2};

	dual_alarm_comparator #(.SEC_CYCLES(SEC)) dut_u (
		.REF_CLK_IN(clk),
		.RST_IN(rst),
		.HSEL_IN(hsel),
		.HADDR_IN(haddr),
		.HTRANS_IN(htrans),
		.HWRITE_IN(hwrite),
		.HSIZE_IN(hsize),
		.HWDATA_IN(hwdata),
		.HREADY_IN(hrdy),
		.HRDATA_OUT(hrdata),
		.HREADYOUT_OUT(hrdy),
		.HRESP_OUT(hresp),
		.DISPLAY_VALUE_IN(disp),
		.ACCEPT_BUTTON_IN(accept),
		.ALARM_FITTED_IN(fitted),
		.MENU_NEXT_IN(mnext),
		.MENU_ITEM_OUT(item),
		.DISPLAY_SHOW_OUT(show),
		.SWITCH1_CLOSED_OUT(sw1),
		.SWITCH2_CLOSED_OUT(sw2),
		.IRQ_OUT(irq)
	);
	// Sounders on both switched circuits
	annunciator_model ann1_u (.closed_in(sw1), .sounding_out(snd1));
	annunciator_model ann2_u (.closed_in(sw2), .sounding_out(snd2));

	// ==========================================================
	// Clock and hang guard
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// The sequence needs several hundred cycles; far beyond that means a hang
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			errors++;
			tally_and_finish();
		end
	end

	// ==========================================================
	// Reference model, comparisons and bus master
	function automatic logic [31:0] fx(input int v);
		return {16'h0, 16'(v)};
	endfunction
	function automatic logic [3:0] next_item(input logic [3:0] e, input logic f);
		if (e == 4'h5)
			return f ? 4'h6 : 4'hE;
		if (e == 4'hD)
			return 4'hE;
		return e + 4'h1;
	endfunction
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
		chk_word({28'h0, got}, {28'h0, exp});
	endtask
	// Single word transfer; both phases held until hready is seen high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk_word(rd, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// New display value, then time for compare, trip and switch to settle
	task automatic put(input int v);
		@(posedge clk);
		disp <= 16'(v);
		cyc(6);
	endtask
	task automatic tally_and_finish();
		if (errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		{rst, fitted} = 2'h3;
		{hsel, hwrite, accept, mnext, htrans, haddr, hwdata, disp} = '0;
		hsize = 3'h2;
		seed = 32'h456af18b;
		errors = 0;
		checks = 0;
		cycles = 0;
		// Menu walk without the option, then with it, each after a reset
		for (int f = 0; f < 2; f++)
		begin
			@(posedge clk);
			rst <= 1'b1;
			fitted <= f[0];
			cyc(8);
			rst <= 1'b0;
			exp_item = 4'h0;
			repeat (16)
			begin
				@(posedge clk);
				mnext <= 1'b1;
				@(posedge clk);
				mnext <= 1'b0;
				@(posedge clk);
				exp_item = next_item(exp_item, f[0]);
				chk_pin(item, exp_item);
			end
		end
		// Limits, unmapped place, clamping of levels and times
		rdc(8'h24, 32'h0000B1E1);
		rdc(8'h28, 32'h00004E1F);
		wr(8'h38, 32'hFFFFFFFF);
		rdc(8'h38, 32'h0);
		wr(8'h04, 32'h7FFF);
		rdc(8'h04, 32'h4E1F);
		wr(8'h04, -25000);
		rdc(8'h04, 32'hB1E1);
		wr(8'h28, 1000);
		wr(8'h08, 5000);
		rdc(8'h08, 32'h3E8);
		wr(8'h28, 19999);
		lvl = $random(seed) % 19999;
		wr(8'h08, lvl);
		rdc(8'h08, fx(lvl));
		wr(8'h1C, 4000);
		rdc(8'h1C, 32'hE10);
		// Channel one high, channel two low with closing contact
		wr(8'h04, 100);
		wr(8'h0C, 20);
		wr(8'h08, -50);
		wr(8'h10, 10);
		wr(8'h1C, 2);
		wr(8'h30, 32'h1);
		wr(8'h00, 32'h53);
		put(0);
		chk_pin({sw1, sw2}, 2'h2);
		for (int i = 0; i < 7; i++)
		begin
			put(tv[i]);
			chk_pin({sw1, sw2}, te[i]);
			chk_pin({snd1, snd2}, te[i]);
		end
		chk_pin(irq, 1'b1);
		rdc(8'h2C, 32'hF);
		cyc(3);
		chk_pin(irq, 1'b0);
		// Masked event stays quiet until the mask opens
		wr(8'h30, 32'h0);
		put(100);
		chk_pin(irq, 1'b0);
		wr(8'h30, 32'h1);
		cyc(3);
		chk_pin(irq, 1'b1);
		rdc(8'h2C, 32'h1);
		cyc(3);
		chk_pin(irq, 1'b0);
		for (k = 0; k < 3 * SEC && show !== 2'h1; k++) @(posedge clk);
		chk_pin(show, 2'h1);
		// Accept silences the output for two ticks, tag stays shown
		@(posedge clk);
		accept <= 1'b1;
		cyc(8);
		chk_pin(sw1, 1'b1);
		accept <= 1'b0;
		for (k = 0; k < 3 * SEC && show !== 2'h1; k++) @(posedge clk);
		chk_pin(show, 2'h1);
		cyc(2 * SEC + 8);
		chk_pin(sw1, 1'b0);
		// Disable drops the alarm but keeps the settings
		wr(8'h00, 32'h52);
		cyc(5);
		chk_pin(sw1, 1'b1);
		rdc(8'h04, 32'h64);
		rdc(8'h0C, 32'h14);
		wr(8'h00, 32'h53);
		cyc(5);
		chk_pin(sw1, 1'b0);
		// Three-second delay: output waits over two ticks, at most three
		put(0);
		wr(8'h14, 3);
		put(150);
		cyc(30);
		chk_pin(sw1, 1'b1);
		cyc(40);
		chk_pin(sw1, 1'b0);
		// Second channel alone in alarm shows its own tag
		put(-60);
		for (k = 0; k < 3 * SEC && show !== 2'h2; k++) @(posedge clk);
		chk_pin(show, 2'h2);
		tally_and_finish();
	end
endmodule
`default_nettype wire
